// ===== src/ubfc_pkg.sv
// constants and register map of the baud and frame configuration block
// assumes an apb master on the bus clock and a serial datapath beside it
//
// Operation
// - software writes the divisor high half first; it only reaches the working divisor when the low half is written.
// - the low half resets non-zero, yet the baud generator idles until receiver or transmitter is first switched on.
// - a combined divisor of zero stops the baud generator completely.
// - a divisor of 1 to 8191 gives a bit rate of bus clock over sixteen times the divisor.
// - bit 7 of the divisor high register lets the line break flag raise the interrupt; otherwise it is polled unless mask bit 0 is set.
// - bit 6 of the divisor high register lets the receive edge flag raise the interrupt; otherwise it is polled unless mask bit 1 is set.
// - loop select routes the transmitter output to the receiver and drops the receive pin.
// - control bit 6 freezes the serial clocks during processor wait; cleared they keep running.
// - receiver source matters only in loop mode: zero is internal loop-back, one is single-wire on the transmit pin.
// - control bit 4 chooses eight data bits, or nine with the extra bit before the stop bit.
// - control bit 3 chooses idle-line wakeup when zero and address-mark wakeup when one.
// - control bit 2 starts the idle count after the start bit when zero, after the stop bit when one.
// - control bit 1 turns on parity generation and checking on the top data bit.
// - control bit 0 chooses even parity when zero and odd when one, parity bit counted.
// - in single-wire mode the direction bit decides whether the transmit pin drives or receives.
package ubfc_pkg;
	// ==========================================================
	// register byte addresses
	localparam logic [7:0] OFS_BDH = 8'h00;
	localparam logic [7:0] OFS_BDL = 8'h04;
	localparam logic [7:0] OFS_CR1 = 8'h08;
	localparam logic [7:0] OFS_CR2 = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_BDH = 8'h00;
	localparam logic [7:0] RST_BDL = 8'h04;
	localparam logic [7:0] RST_CR1 = 8'h00;
	localparam logic [7:0] RST_CR2 = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	// ==========================================================
	// field positions
	localparam int BDH_BRK_IE = 7;
	localparam int BDH_EDGE_IE = 6;
	localparam int BDH_DIV_HI = 4;
	localparam int CR1_LOOP = 7;
	localparam int CR1_WAIT_STOP = 6;
	localparam int CR1_RECEIVER_SOURCE = 5;
	localparam int CR1_NINE = 4;
	localparam int CR1_WAKE = 3;
	localparam int CR1_ILT = 2;
	localparam int CR1_PEN = 1;
	localparam int CR1_PODD = 0;
	localparam int CR2_TXON = 0;
	localparam int CR2_RXON = 1;
	localparam int CR2_DIR = 2;
	localparam int ST_BRK = 0;
	localparam int ST_EDGE = 1;
	// ==========================================================
	// timing
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
endpackage : ubfc_pkg

// ===== src/ubfc_top.sv
// baud divisor, control register one and interrupt logic of the uart
// assumes apb on CORE_CLK; datapath consumes ticks and config outputs
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ubfc_top
	import ubfc_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic WAIT_MODE,
	input wire logic LINE_BREAK_EVT,
	input wire logic RX_EDGE_EVT,
	input wire logic TX_SERIAL,
	input wire logic RX_PIN_I,
	input wire logic TX_PIN_I,
	output logic TX_PIN_O,
	output logic TX_PIN_OE,
	output logic RX_SERIAL,
	output logic SAMPLE_TICK,
	output logic BAUD_ACTIVE,
	output logic NINE_BIT,
	output logic WAKE_ADDR,
	output logic IDLE_AFTER_STOP,
	output logic PARITY_ENABLE,
	output logic PARITY_ODD,
	output logic RX_ENABLE,
	output logic TX_ENABLE,
	output logic IRQ
);
	// ==========================================================
	// apb decode
	logic acc, wr, rd;
	logic [7:0] bdh_reg, bdh_buf_reg, bdl_reg, cr1_reg, cr2_reg, mask_reg;
	logic [1:0] stat_reg, stat_next;
	logic [12:0] div_reg, cnt_reg;
	logic [3:0] sub_reg;
	logic started_reg;
	logic [31:0] rdata_next;
	logic mapped;

	assign acc = PSEL && PENABLE && PREADY;
	assign wr = acc && PWRITE;
	assign rd = acc && !PWRITE;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// one wait state: ready rises in the second access cycle
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			PREADY <= 1'b0;
		end else begin
			PREADY <= PSEL && PENABLE && !PREADY;
		end
	end

	always_comb begin
		mapped = 1'b1;
		rdata_next = 32'h0;
		unique case (PADDR)
			OFS_BDH: rdata_next = {24'h0, bdh_reg[7:6], 1'b0, div_reg[12:8]};
			OFS_BDL: rdata_next = {24'h0, bdl_reg};
			OFS_CR1: rdata_next = {24'h0, cr1_reg};
			OFS_CR2: rdata_next = {24'h0, cr2_reg};
			OFS_STAT: rdata_next = {30'h0, stat_reg};
			OFS_MASK: rdata_next = {24'h0, mask_reg};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
		end else begin
			PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rdata_next
				: 32'h0;
			PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			bdh_reg <= RST_BDH;
			bdh_buf_reg <= RST_BDH;
			bdl_reg <= RST_BDL;
			cr1_reg <= RST_CR1;
			cr2_reg <= RST_CR2;
			mask_reg <= RST_MASK;
		end else if (wr) begin
			if (hit(PADDR, OFS_BDH)) begin
				// enables act at once, divisor bits wait for low half
				bdh_reg[7:6] <= PWDATA[7:6];
				bdh_buf_reg <= PWDATA[7:0];
			end
			if (hit(PADDR, OFS_BDL)) begin
				bdl_reg <= PWDATA[7:0];
				bdh_reg[4:0] <= bdh_buf_reg[4:0];
			end
			if (hit(PADDR, OFS_CR1)) begin
				cr1_reg <= PWDATA[7:0];
			end
			if (hit(PADDR, OFS_CR2)) begin
				cr2_reg <= {5'h0, PWDATA[2:0]};
			end
			if (hit(PADDR, OFS_MASK)) begin
				mask_reg <= {6'h0, PWDATA[1:0]};
			end
		end
	end

	assign div_reg = {bdh_reg[BDH_DIV_HI:0], bdl_reg};

	// ==========================================================
	// baud generator
	logic run;
	// generator held off until the first enable, then off on zero
	assign run = started_reg && (div_reg != 13'h0)
		&& !(cr1_reg[CR1_WAIT_STOP] && WAIT_MODE);

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			started_reg <= 1'b0;
		end else if (cr2_reg[CR2_TXON] || cr2_reg[CR2_RXON]) begin
			started_reg <= 1'b1;
		end
	end

	// count divisor bus clocks per tick, 16 ticks per bit
	always_ff @(posedge CORE_CLK) begin
		if (SRST || !run) begin
			cnt_reg <= 13'h0;
			sub_reg <= 4'h0;
			SAMPLE_TICK <= 1'b0;
		end else if (cnt_reg >= div_reg - 13'h1) begin
			cnt_reg <= 13'h0;
			SAMPLE_TICK <= 1'b1;
			sub_reg <= (sub_reg == TICK_LAST) ? 4'h0 : sub_reg + 4'h1;
		end else begin
			cnt_reg <= cnt_reg + 13'h1;
			SAMPLE_TICK <= 1'b0;
		end
	end

	// ==========================================================
	// frame config and pin routing
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			BAUD_ACTIVE <= 1'b0;
			NINE_BIT <= 1'b0;
			WAKE_ADDR <= 1'b0;
			IDLE_AFTER_STOP <= 1'b0;
			PARITY_ENABLE <= 1'b0;
			PARITY_ODD <= 1'b0;
			RX_ENABLE <= 1'b0;
			TX_ENABLE <= 1'b0;
			RX_SERIAL <= 1'b1;
			TX_PIN_O <= 1'b1;
			TX_PIN_OE <= 1'b0;
		end else begin
			BAUD_ACTIVE <= run;
			NINE_BIT <= cr1_reg[CR1_NINE];
			WAKE_ADDR <= cr1_reg[CR1_WAKE];
			IDLE_AFTER_STOP <= cr1_reg[CR1_ILT];
			PARITY_ENABLE <= cr1_reg[CR1_PEN];
			PARITY_ODD <= cr1_reg[CR1_PEN] && cr1_reg[CR1_PODD];
			RX_ENABLE <= cr2_reg[CR2_RXON];
			TX_ENABLE <= cr2_reg[CR2_TXON];
			TX_PIN_O <= TX_SERIAL;
			if (!cr1_reg[CR1_LOOP]) begin
				RX_SERIAL <= RX_PIN_I;
				TX_PIN_OE <= cr2_reg[CR2_TXON];
			end else if (!cr1_reg[CR1_RECEIVER_SOURCE]) begin
				RX_SERIAL <= TX_SERIAL;
				TX_PIN_OE <= cr2_reg[CR2_TXON];
			end else begin
				// single wire: pin either drives or listens
				TX_PIN_OE <= cr2_reg[CR2_TXON] && cr2_reg[CR2_DIR];
				RX_SERIAL <= cr2_reg[CR2_DIR] ? TX_SERIAL : TX_PIN_I;
			end
		end
	end

	// ==========================================================
	// interrupts: set beats a clearing read
	always_comb begin
		stat_next = stat_reg;
		if (rd && hit(PADDR, OFS_STAT)) begin
			stat_next = 2'b00;
		end
		if (LINE_BREAK_EVT) begin
			stat_next[ST_BRK] = 1'b1;
		end
		if (RX_EDGE_EVT) begin
			stat_next[ST_EDGE] = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			stat_reg <= 2'b00;
			IRQ <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			IRQ <= (stat_next[ST_BRK] && bdh_reg[BDH_BRK_IE])
				|| (stat_next[ST_EDGE] && bdh_reg[BDH_EDGE_IE])
				|| |(stat_next & mask_reg[1:0]);
		end
	end

	// ==========================================================
	// checks
	a_zero_div_idle: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(div_reg == 13'h0) |=> !SAMPLE_TICK)
		else $error("tick with zero divisor");
	a_no_start_idle: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!started_reg |-> !SAMPLE_TICK)
		else $error("tick before enable");
	a_hi_buffered: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(wr && hit(PADDR, OFS_BDH)) |=> $stable(div_reg[12:8]))
		else $error("divisor high changed early");
	a_tick_single: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(SAMPLE_TICK && div_reg > 13'h1 && $stable(div_reg))
		|=> !SAMPLE_TICK)
		else $error("tick too soon");
	a_loop_route: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(cr1_reg[CR1_LOOP] && !cr1_reg[CR1_RECEIVER_SOURCE])
		|=> RX_SERIAL == $past(TX_SERIAL))
		else $error("loop not routed");
	a_wait_freeze: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(cr1_reg[CR1_WAIT_STOP] && WAIT_MODE) |=> !SAMPLE_TICK)
		else $error("tick during wait");
	a_brk_irq: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(LINE_BREAK_EVT && bdh_reg[BDH_BRK_IE]) |=> IRQ)
		else $error("break irq missing");
	a_edge_irq: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(RX_EDGE_EVT && bdh_reg[BDH_EDGE_IE]) |=> IRQ)
		else $error("edge irq missing");
	a_sw_dir: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(cr1_reg[CR1_LOOP] && cr1_reg[CR1_RECEIVER_SOURCE] && !cr2_reg[CR2_DIR])
		|=> !TX_PIN_OE)
		else $error("pin driven while listening");
	a_parity_cfg: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!cr1_reg[CR1_PEN] |=> !PARITY_ENABLE && !PARITY_ODD)
		else $error("parity without enable");
	// ==========================================================
	// bus handshake: one wait state, answer for one cycle only
	a_ready_pulse: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		PREADY |=> !PREADY)
		else $error("ready held too long");
	a_ready_wait: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(PSEL && PENABLE && !PREADY) |=> PREADY)
		else $error("ready missing");
	a_ready_idle: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!PSEL |=> !PREADY)
		else $error("ready without select");
	a_err_unmapped: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(PSEL && PENABLE && !PREADY && !mapped) |=> PSLVERR)
		else $error("unmapped access not flagged");
	a_err_ready: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		PSLVERR |-> PREADY)
		else $error("error without ready");
	a_rdata_idle: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!PREADY |-> (PRDATA == 32'h0))
		else $error("read data outside answer");
	a_lo_commit: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(wr && hit(PADDR, OFS_BDL))
		|=> (div_reg[12:8] == $past(bdh_buf_reg[4:0])))
		else $error("buffered high half not committed");
	a_lo_value: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(wr && hit(PADDR, OFS_BDL)) |=> (bdl_reg == $past(PWDATA[7:0])))
		else $error("low half not written");
	a_ie_direct: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(wr && hit(PADDR, OFS_BDH)) |=> (bdh_reg[7:6] == $past(PWDATA[7:6])))
		else $error("interrupt enables not written");
	a_div_hold: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!(wr && hit(PADDR, OFS_BDL)) |=> $stable(div_reg[12:8]))
		else $error("divisor high moved without low write");
	// ==========================================================
	// generator enables
	a_started_sticky: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		started_reg |=> started_reg)
		else $error("start memory lost");
	a_start_set: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(cr2_reg[CR2_TXON] || cr2_reg[CR2_RXON]) |=> started_reg)
		else $error("start not remembered");
	a_active_on: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		run |=> BAUD_ACTIVE)
		else $error("active flag missing");
	a_active_off: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!run |=> !BAUD_ACTIVE)
		else $error("active flag while stopped");
	a_tick_run: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!run |=> !SAMPLE_TICK)
		else $error("tick while stopped");
	a_sub_idle: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!run |=> (sub_reg == 4'h0))
		else $error("tick phase not cleared");
	// ==========================================================
	// frame config copies
	a_nine_copy: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		cr1_reg[CR1_NINE] |=> NINE_BIT)
		else $error("nine bit not passed on");
	a_wake_copy: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		cr1_reg[CR1_WAKE] |=> WAKE_ADDR)
		else $error("wakeup method not passed on");
	a_ilt_copy: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		cr1_reg[CR1_ILT] |=> IDLE_AFTER_STOP)
		else $error("idle start not passed on");
	a_pen_copy: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		cr1_reg[CR1_PEN] |=> PARITY_ENABLE)
		else $error("parity enable not passed on");
	a_odd_copy: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(cr1_reg[CR1_PEN] && cr1_reg[CR1_PODD]) |=> PARITY_ODD)
		else $error("odd parity not passed on");
	// ==========================================================
	// pin routing
	a_rx_normal: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!cr1_reg[CR1_LOOP] |=> (RX_SERIAL == $past(RX_PIN_I)))
		else $error("receive pin not routed");
	a_sw_drive: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(cr1_reg[CR1_LOOP] && cr1_reg[CR1_RECEIVER_SOURCE] && cr2_reg[CR2_DIR])
		|=> (RX_SERIAL == $past(TX_SERIAL)))
		else $error("single wire drive not looped");
	a_sw_listen: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(cr1_reg[CR1_LOOP] && cr1_reg[CR1_RECEIVER_SOURCE] && !cr2_reg[CR2_DIR])
		|=> (RX_SERIAL == $past(TX_PIN_I)))
		else $error("single wire not listening");
	a_pin_follow: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		TX_SERIAL |=> TX_PIN_O)
		else $error("pin not high");
	a_pin_low: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!TX_SERIAL |=> !TX_PIN_O)
		else $error("pin not low");
	// ==========================================================
	// status and interrupt
	a_brk_sticky: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		LINE_BREAK_EVT |=> stat_reg[ST_BRK])
		else $error("break flag not set");
	a_edge_sticky: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		RX_EDGE_EVT |=> stat_reg[ST_EDGE])
		else $error("edge flag not set");
	a_stat_clear: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(rd && hit(PADDR, OFS_STAT)
		&& !LINE_BREAK_EVT && !RX_EDGE_EVT) |=> (stat_reg == 2'b00))
		else $error("status not cleared by read");
	a_mask_irq: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		(|(stat_reg & mask_reg[1:0]) && !rd) |=> IRQ)
		else $error("masked-in flag without irq");
endmodule // ubfc_top
`default_nettype wire

// ===== verif/ubfc_peer.sv
// far-side transceiver model: drives the receive pin and the shared wire
// assumes the bench picks the levels it sends on each line
`timescale 1ns/1ps
`default_nettype none
module ubfc_peer (
	input wire logic clk,
	input wire logic pin_o,
	input wire logic pin_oe,
	input wire logic send_rx,
	input wire logic send_tx,
	output logic rx_line,
	output logic tx_wire
);
	// ==========================================================
	// line drive
	// peer yields the shared wire while the unit drives it
	always_comb tx_wire = pin_oe ? pin_o : send_tx;
	always_ff @(posedge clk) rx_line <= send_rx;
endmodule // ubfc_peer
`default_nettype wire

// ===== verif/test_uart_baud_and_frame_config.sv
// self-checking bench of the baud and frame configuration block
// assumes ubfc_pkg and the peer model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_uart_baud_and_frame_config;
	import ubfc_pkg::*;
	logic clk = 0, srst = 1, psel = 0, pen = 0, pw = 0, wt = 0;
	logic brk = 0, edg = 0, txs = 1, srx = 1, stx = 1;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic prdy, perr, er, rxp, txw, po, poe, rxs, tick, act;
	logic nine, wk, ias, pe, podd, irq;
	logic rxe, txe;
	int errors = 0, compares = 0, bdb = 0, bdl = 4, bdh = 0, n, v, m;
	int modes[4] = '{32'h00, 32'h80, 32'ha0, 32'ha0};
	always #10 clk = ~clk;
	ubfc_top u_dut(.CORE_CLK(clk), .SRST(srst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pw), .PADDR(pa), .PWDATA(pwd),
		.PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .WAIT_MODE(wt),
		.LINE_BREAK_EVT(brk), .RX_EDGE_EVT(edg), .TX_SERIAL(txs),
		.RX_PIN_I(rxp), .TX_PIN_I(txw), .TX_PIN_O(po), .TX_PIN_OE(poe),
		.RX_SERIAL(rxs), .SAMPLE_TICK(tick), .BAUD_ACTIVE(act),
		.NINE_BIT(nine), .WAKE_ADDR(wk), .IDLE_AFTER_STOP(ias),
		.PARITY_ENABLE(pe), .PARITY_ODD(podd), .RX_ENABLE(rxe),
		.TX_ENABLE(txe), .IRQ(irq));
	ubfc_peer u_peer(.clk(clk), .pin_o(po), .pin_oe(poe), .send_rx(srx),
		.send_tx(stx), .rx_line(rxp), .tx_wire(txw));
	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input int d);
		@(posedge clk);
		psel <= 1;
		pw <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 0;
		pen <= 0;
	endtask
	// model: high half sits in a buffer until the low half lands
	task automatic wr(input logic [7:0] a, input int d);
		apb(1, a, d);
		if (a == OFS_BDH)
			bdb = d;
		if (a == OFS_BDL) begin
			bdl = d;
			bdh = bdb;
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic tck;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (tick !== 1'b1 && n < 9000);
		end
		chk(n, (bdh & 31) * 256 + bdl);
	endtask
	task automatic pulse(input int b);
		brk <= b[0];
		edg <= b[1];
		@(posedge clk);
		brk <= 0;
		edg <= 0;
		repeat (3) @(posedge clk);
	endtask
	task automatic close_out;
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// watchdog
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		close_out;
	end
	// ==========================================================
	// tests
	initial begin
		v = $urandom(32'h99b5);
		repeat (10) @(posedge clk);
		srst <= 0;
		apb(0, OFS_BDH, 0);
		chk(rd, RST_BDH);
		apb(0, OFS_BDL, 0);
		chk(rd, RST_BDL);
		apb(0, OFS_CR1, 0);
		chk(rd, RST_CR1);
		apb(1, 8'h18, 5);
		chk({er, rd[30:0]}, 32'h80000000);
		chk(act, 0);
		wr(OFS_BDH, 32'hc1);
		apb(0, OFS_BDH, 0);
		chk(rd, 32'hc0);
		wr(OFS_BDL, 0);
		apb(0, OFS_BDH, 0);
		chk(rd, 32'hc1);
		wr(OFS_CR2, 3);
		chk(act, 1);
		chk({rxe, txe}, 2'b11);
		tck;
		pulse(1);
		chk(irq, 1);
		apb(0, OFS_STAT, 0);
		chk(rd, 1);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		wr(OFS_BDH, 0);
		pulse(2);
		chk(irq, 0);
		wr(OFS_MASK, 2);
		chk(irq, 1);
		apb(0, OFS_STAT, 0);
		chk(rd, 2);
		repeat (3) begin
			wr(OFS_BDL, $urandom_range(40, 1));
			tck;
		end
		wr(OFS_BDL, 0);
		chk(act, 0);
		wr(OFS_BDL, 3);
		wr(OFS_CR1, 32'h40);
		wt <= 1;
		repeat (3) @(posedge clk);
		chk(act, 0);
		wr(OFS_CR1, 0);
		chk(act, 1);
		wt <= 0;
		repeat (8) begin
			v = $urandom & 32'h5f;
			wr(OFS_CR1, v);
			chk({nine, wk, ias, pe, podd}, {v[4:1], v[1] & v[0]});
			apb(0, OFS_CR1, 0);
			chk(rd, v);
		end
		// two level sets so receive pin and shared wire differ from the transmit data
		for (int s = 0; s < 2; s++)
			for (int i = 0; i < 4; i++) begin
				txs <= s[0];
				srx <= !s[0];
				stx <= !s[0];
				wr(OFS_CR2, 3 + 4 * (i == 3 ? 1 : 0));
				wr(OFS_CR1, modes[i]);
				m = modes[i];
				v = (!m[7] || (m[5] && i == 2)) ? !s[0] : s[0];
				chk(rxs, v[0]);
				chk(po, s[0]);
				if (m[5])
					chk(poe, i == 3);
			end
		close_out;
	end
endmodule // test_uart_baud_and_frame_config
`default_nettype wire
